// >>> pma_map.vh
// Constants for the programmable macrocell array
`ifndef PMA_MAP_VH
`define PMA_MAP_VH
// ****************************************************************
// Sizes
// ****************************************************************
`define PMA_NUM_IN 12
`define PMA_NUM_MC 10
`define PMA_NUM_TERMS 16
`define PMA_SIG_BITS 64
`define PMA_ROW_BITS 44
// ****************************************************************
// Configuration store layout, one word per entry
// ****************************************************************
`define PMA_CFG_WORDS 256
`define PMA_CFG_AW 8
// Word 16*m+t : product term t of macrocell m (t<16), AND mask
// Word 160+m : output enable term of macrocell m
// Word 170+m : cell mode, bit0 registered, bit1 active low
// Word 180+m : number of OR terms for macrocell m (8..16)
// Word 190 : async clear term, word 191 : sync preset term
// Word 192..193 : signature low and high halves (32 bits each)
`define PMA_OE_BASE 8'hA0
`define PMA_MODE_BASE 8'hAA
`define PMA_CNT_BASE 8'hB4
`define PMA_ACLR_ADDR 8'hBE
`define PMA_SPRE_ADDR 8'hBF
`define PMA_SIG_LO 8'hC0
`define PMA_SIG_HI 8'hC1
`define PMA_MODE_REG_BIT 0
`define PMA_MODE_LOW_BIT 1
`define PMA_TERM_MIN 5'h08
// ****************************************************************
// Power-up clear interval
// ****************************************************************
`define PMA_PUC_NS 1000
`define PMA_CLK_NS 10
`define PMA_PUC_CYC ((`PMA_PUC_NS + `PMA_CLK_NS - 1) / `PMA_CLK_NS)
`endif

// >>> pma_term.v
// One AND product term with a per-literal mask
`timescale 1ns/1ps
`include "pma_map.vh"
module pma_term #(
    parameter W = 22
) (
    // Literals in true and complement pairs
    input wire [2*W-1:0] lit_in,
    // Fuse mask: one bit keeps a literal in the term
    input wire [2*W-1:0] mask_in,
    // Term result
    output wire term_out
);
    // Term is true when all selected literals are true; empty term is 0
    assign term_out = (|mask_in) & (&(lit_in | ~mask_in));
endmodule

// >>> pma_array.v
// Programmable macrocell array core with configuration port
`timescale 1ns/1ps
`include "pma_map.vh"
module pma_array #(
    parameter NI = `PMA_NUM_IN,
    parameter NM = `PMA_NUM_MC,
    parameter PUC_CYC = `PMA_PUC_CYC
) (
    // Clock and reset
    input wire core_clk_in,
    input wire resetn_in,
    // Logic pins
    input wire [NI-1:0] pin_in,
    input wire output_enable_in,
    input wire [NM-1:0] io_in,
    output reg [NM-1:0] io_out,
    output reg [NM-1:0] io_oe_out,
    // Configuration port
    input wire [`PMA_CFG_AW-1:0] cfg_addr_in,
    input wire [31:0] cfg_wdata_in,
    input wire cfg_write_in,
    input wire cfg_read_in,
    output reg [31:0] cfg_rdata_out,
    // Security fuse program, preload strobe and data
    input wire secure_set_in,
    input wire preload_in,
    input wire [NM-1:0] preload_data_in,
    // Status
    output reg secured_out,
    output reg clear_busy_out
);
    // ************************************************************
    // Store layout and literal order
    // ************************************************************
    // Literal vector, low to high:
    //   bits 0..NI-1       dedicated input pins
    //   bits NI..LW-1      macrocell feedback
    //   bits LW..2*LW-1    complements of the above
    // A mask word keeps a literal in the term where its bit is set.
    // Only the low 32 mask bits can be written, so the upper
    // complement literals always stay out of every term.
    // An all-zero mask gives a term that is always false, so a term
    // written as zero never disturbs a sum.
    // Feedback of a registered cell comes from its own register, so
    // the state holds whether or not the pin is driven; feedback of
    // a combinational cell comes from the sensed pin level.
    // Clear has priority over preload, preload over preset, and
    // preset over the array data.
    // The clear term acts at once, without waiting for a clock.
    // During the power-up clear interval every macrocell register is
    // low, so registered outputs show only their polarity, while
    // combinational outputs still follow the array.
    // The security fuse stays set until the next power-up reset.
    localparam LW = NI + NM;
    localparam ST_CLEAR = 2'b01;
    localparam ST_RUN = 2'b10;

    // Configuration store
    reg [2*LW-1:0] cfg_mem [0:`PMA_CFG_WORDS-1];
    reg [NM-1:0] cell_reg;
    reg [NM-1:0] cell_next;
    reg [NI-1:0] pin_keep_reg;
    reg [NM-1:0] io_keep_reg;
    reg secure_reg;
    reg [1:0] state_reg;
    reg [1:0] state_next;
    reg [10:0] puc_cnt_reg;
    reg [NM-1:0] out_next;
    reg [NM-1:0] oe_next;
    reg [31:0] rdata_next;
    wire [LW-1:0] lit;
    wire [2*LW-1:0] lit2;
    wire aclr_term;
    wire spre_term;
    wire [NM-1:0] oe_term;
    wire [NM-1:0] sop;
    wire [NM-1:0] comb_val;
    wire [NM-1:0] fb;
    integer i;

    // ************************************************************
    // Pin keepers and literal vector
    // ************************************************************
    // Keeper registers sample every pin each clock; the literals take the pins directly
    always @(posedge core_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            pin_keep_reg <= {NI{1'b0}};
            io_keep_reg <= {NM{1'b0}};
        end else begin
            pin_keep_reg <= pin_in;
            io_keep_reg <= io_in;
        end
    end
    // Registered cells feed back their register, others their pin
    assign lit = {fb, pin_in};
    assign lit2 = {~lit, lit};

    // ************************************************************
    // Product terms and sums
    // ************************************************************
    genvar m, t;
    generate
        for (m = 0; m < NM; m = m + 1) begin : g_cell
            wire [`PMA_NUM_TERMS-1:0] pt;
            wire [4:0] cnt = cfg_mem[`PMA_CNT_BASE + m][4:0];
            // Feedback source per cell
            assign fb[m] = cfg_mem[`PMA_MODE_BASE + m][`PMA_MODE_REG_BIT]
                ? cell_reg[m] : io_in[m];
            for (t = 0; t < `PMA_NUM_TERMS; t = t + 1) begin : g_pt
                pma_term #(.W(LW)) u_pt (
                    .lit_in(lit2),
                    .mask_in(cfg_mem[m * `PMA_NUM_TERMS + t]),
                    .term_out(pt[t])
                );
            end
            // Only the first cnt terms feed the sum, clamped 8..16
            wire [4:0] ncnt = (cnt < `PMA_TERM_MIN) ? `PMA_TERM_MIN :
                              (cnt > 5'h10) ? 5'h10 : cnt;
            wire [`PMA_NUM_TERMS-1:0] use_mask =
                ~({`PMA_NUM_TERMS{1'b1}} << ncnt);
            assign sop[m] = |(pt & use_mask);
            pma_term #(.W(LW)) u_oe (
                .lit_in(lit2),
                .mask_in(cfg_mem[`PMA_OE_BASE + m]),
                .term_out(oe_term[m])
            );
        end
    endgenerate

    pma_term #(.W(LW)) u_aclr (
        .lit_in(lit2),
        .mask_in(cfg_mem[`PMA_ACLR_ADDR]),
        .term_out(aclr_term)
    );
    pma_term #(.W(LW)) u_spre (
        .lit_in(lit2),
        .mask_in(cfg_mem[`PMA_SPRE_ADDR]),
        .term_out(spre_term)
    );
    assign comb_val = sop;

    // ************************************************************
    // Power-up clear sequencer
    // ************************************************************
    // Hold registers cleared for the power-up clear interval
    always @* begin
        state_next = state_reg;
        case (state_reg)
            ST_CLEAR: begin
                if ({21'h000000, puc_cnt_reg} == PUC_CYC - 1)
                    state_next = ST_RUN;
            end
            ST_RUN: state_next = ST_RUN;
            default: state_next = ST_CLEAR;
        endcase
    end
    always @(posedge core_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            state_reg <= ST_CLEAR;
            puc_cnt_reg <= 11'h000;
        end else begin
            state_reg <= state_next;
            if (state_reg == ST_CLEAR)
                puc_cnt_reg <= puc_cnt_reg + 11'h001;
        end
    end

    // ************************************************************
    // Macrocell registers
    // ************************************************************
    // Priority: async clear, power-up clear, preload, preset, data
    always @* begin
        cell_next = comb_val;
        if (preload_in && !secure_reg)
            cell_next = preload_data_in;
        else if (spre_term)
            cell_next = {NM{1'b1}};
    end
    // Array clear term clears the registers without a clock
    always @(posedge core_clk_in or negedge resetn_in or
        posedge aclr_term) begin
        if (!resetn_in)
            cell_reg <= {NM{1'b0}};
        else if (aclr_term)
            cell_reg <= {NM{1'b0}};
        else if (state_reg != ST_RUN)
            cell_reg <= {NM{1'b0}};
        else
            cell_reg <= cell_next;
    end

    // ************************************************************
    // Output stage
    // ************************************************************
    // Select register or array value, apply polarity and enables
    always @* begin
        for (i = 0; i < NM; i = i + 1) begin
            out_next[i] = cfg_mem[`PMA_MODE_BASE + i][`PMA_MODE_REG_BIT]
                ? cell_reg[i] : comb_val[i];
            out_next[i] = out_next[i] ^
                cfg_mem[`PMA_MODE_BASE + i][`PMA_MODE_LOW_BIT];
            oe_next[i] = oe_term[i] & output_enable_in;
        end
    end
    // Registered pin drive; undriven pins held by the keeper
    always @(posedge core_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            io_out <= {NM{1'b0}};
            io_oe_out <= {NM{1'b0}};
        end else begin
            io_out <= out_next;
            io_oe_out <= oe_next;
        end
    end

    // ************************************************************
    // Configuration port and security
    // ************************************************************
    // Fuse is sticky until reset and acts from the next clock edge
    always @(posedge core_clk_in or negedge resetn_in) begin
        if (!resetn_in)
            secure_reg <= 1'b0;
        else if (secure_set_in)
            secure_reg <= 1'b1;
    end
    // Writes to the store; signature words stay writable
    always @(posedge core_clk_in) begin
        if (cfg_write_in && (!secure_reg ||
            cfg_addr_in == `PMA_SIG_LO || cfg_addr_in == `PMA_SIG_HI))
            cfg_mem[cfg_addr_in] <= {{(2*LW-32){1'b0}}, cfg_wdata_in};
    end
    // Readback blocked when secured except for the signature
    always @* begin
        rdata_next = 32'h0000_0000;
        if (cfg_read_in) begin
            if (cfg_addr_in == `PMA_SIG_LO || cfg_addr_in == `PMA_SIG_HI)
                rdata_next = cfg_mem[cfg_addr_in][31:0];
            else if (!secure_reg)
                rdata_next = cfg_mem[cfg_addr_in][31:0];
        end
    end
    always @(posedge core_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            cfg_rdata_out <= 32'h0000_0000;
            secured_out <= 1'b0;
            clear_busy_out <= 1'b1;
        end else begin
            cfg_rdata_out <= rdata_next;
            secured_out <= secure_reg | secure_set_in;
            clear_busy_out <= (state_next != ST_RUN);
        end
    end
endmodule

// >>> pma_props_properties.sv
// Port checker for the macrocell array
`timescale 1ns/1ps
module pma_props #(
    parameter int PUC_CYC = 4
) (
    // Clock, reset and pins
    input wire core_clk_in,
    input wire resetn_in,
    input wire output_enable_in,
    input wire [9:0] io_oe_out,
    // Configuration, preload and fuse
    input wire [7:0] cfg_addr_in,
    input wire cfg_read_in,
    input wire [31:0] cfg_rdata_out,
    input wire secure_set_in,
    input wire preload_in,
    input wire secured_out,
    input wire clear_busy_out
);
    // ********
    // Checks
    // ********
    localparam int PUC_MAX = PUC_CYC + 2;
    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (!resetn_in);
    property p_busy_start; $rose(resetn_in) |-> clear_busy_out; endproperty
    property p_puc_end; $rose(resetn_in) |-> ##[1:PUC_MAX] !clear_busy_out;
    endproperty
    property p_busy_quiet; !clear_busy_out |=> !clear_busy_out; endproperty
    property p_rd_idle; !$past(cfg_read_in) |-> cfg_rdata_out == 32'h0;
    endproperty
    property p_oe_pin; !output_enable_in |=> io_oe_out == 10'h000; endproperty
    property p_sec_rd;
        secured_out && cfg_read_in && cfg_addr_in[7:1] != 7'h60
        |=> cfg_rdata_out == 32'h0;
    endproperty
    property p_sec_set; secure_set_in |=> secured_out; endproperty
    property p_sec_hold; secured_out |=> secured_out; endproperty
    a_busy_start: assert property (p_busy_start) else $error("busy");
    a_puc_end: assert property (p_puc_end) else $error("clear long");
    a_busy_quiet: assert property (p_busy_quiet) else $error("busy");
    a_rd_idle: assert property (p_rd_idle) else $error("rdata");
    a_oe_pin: assert property (p_oe_pin) else $error("oe pin");
    a_sec_rd: assert property (p_sec_rd) else $error("readback");
    a_sec_set: assert property (p_sec_set) else $error("fuse");
    a_sec_hold: assert property (p_sec_hold) else $error("fuse");
    // Main scenarios reached
    c_secure: cover property ($rose(secured_out));
    c_preload: cover property (preload_in && !secured_out);
    c_oe: cover property (io_oe_out == 10'h3FF);
endmodule
bind pma_array pma_props #(.PUC_CYC(PUC_CYC)) u_props (.*);

// >>> pma_keeper.sv
// Pin keeper model for the ten I/O pins
`timescale 1ns/1ps
module pma_keeper (
    // Design side
    input wire [9:0] io_drv_in,
    input wire [9:0] io_en_in,
    // Pin level seen by the array
    output logic [9:0] io_lvl_out
);
    // Released pins keep their last driven level
    initial io_lvl_out = 10'h000;
    always @* begin
        for (int i = 0; i < 10; i++)
            if (io_en_in[i]) io_lvl_out[i] = io_drv_in[i];
    end
endmodule

// >>> tb_programmable_macrocell_array.sv
// Self-checking bench for the macrocell array
`timescale 1ns/1ps
module tb_programmable_macrocell_array;
    // ********
    // Stimulus, wiring and tasks
    // ********
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [11:0] pins = 12'h000;
    logic oe_pin = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic sec = 1'b0;
    logic pl = 1'b0;
    logic [9:0] pld = 10'h000;
    wire [9:0] io_lvl, io_val, io_en;
    wire [31:0] rdata;
    wire secured, busy;
    int err_total = 0;
    int compares = 0;
    logic [31:0] rv;
    pma_array #(.PUC_CYC(4)) DUT (.core_clk_in(clk), .resetn_in(rst_n),
        .pin_in(pins), .output_enable_in(oe_pin), .io_in(io_lvl),
        .io_out(io_val), .io_oe_out(io_en), .cfg_addr_in(addr),
        .cfg_wdata_in(wdata), .cfg_write_in(wr), .cfg_read_in(rd),
        .cfg_rdata_out(rdata), .secure_set_in(sec), .preload_in(pl),
        .preload_data_in(pld), .secured_out(secured),
        .clear_busy_out(busy));
    pma_keeper u_keep (.io_drv_in(io_val), .io_en_in(io_en),
        .io_lvl_out(io_lvl));
    // Free running clock
    always #5 clk = ~clk;
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            err_total++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic wr32(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk) addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk) wr <= 1'b0;
    endtask
    task automatic rd32(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk) addr <= a;
        rd <= 1'b1;
        @(posedge clk) rd <= 1'b0;
        #1 d = rdata;
    endtask
    task automatic preload(input logic v);
        @(posedge clk) pld <= {9'h000, v};
        pl <= 1'b1;
        @(posedge clk) pl <= 1'b0;
        tick(3);
    endtask
    task automatic end_of_test;
        $display("Compares %0d, errors %0d", compares, err_total);
        if (err_total == 0 && compares > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    task automatic t_reset;
        tick(2);
        chk(io_val, 32'h0);
        chk(busy, 32'h1);
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        tick(1);
        chk(busy, 32'h1);
        tick(3);
        chk(busy, 32'h0);
    endtask
    task automatic t_config;
        for (int a = 0; a < 194; a++) wr32(a[7:0], 32'h0);
        for (int m = 0; m < 10; m++) begin
            wr32(8'hA0 + m[7:0], 32'h800);
            wr32(8'hB4 + m[7:0], 32'h8);
        end
        wr32(8'hB8, 32'h10);
        wr32(8'h00, 32'h1000);
        wr32(8'h10, 32'h3);
        wr32(8'h20, 32'h4);
        wr32(8'h48, 32'h20);
        wr32(8'h58, 32'h20);
        wr32(8'hAA, 32'h1);
        wr32(8'hAC, 32'h2);
        wr32(8'hAD, 32'h3);
        wr32(8'hAE, 32'h1);
        wr32(8'hAF, 32'h1);
        wr32(8'hBE, 32'h10);
        wr32(8'hBF, 32'h8);
        tick(3);
        chk(io_val[3], 32'h1);
    endtask
    task automatic t_comb;
        for (int k = 0; k < 4; k++) begin
            @(posedge clk) pins[2:0] <= {k[0], k[1:0]};
            tick(2);
            chk(io_val[2:1], {~k[0], &k[1:0]});
        end
    endtask
    task automatic t_oe;
        for (int k = 0; k < 4; k++) begin
            @(posedge clk) {oe_pin, pins[11]} <= k[1:0];
            tick(2);
            chk(io_en, {10{&k[1:0]}});
        end
    endtask
    task automatic t_count;
        @(posedge clk) pins[5] <= 1'b1;
        tick(3);
        chk(io_val[5:4], 32'h1);
        @(posedge clk) pins[5] <= 1'b0;
    endtask
    task automatic t_preload;
        preload(1'b1);
        chk(io_val[0], 32'h1);
        @(posedge clk) oe_pin <= 1'b0;
        tick(4);
        chk(io_val[0], 32'h1);
        @(posedge clk) oe_pin <= 1'b1;
        preload(1'b0);
        chk(io_val[0], 32'h0);
    endtask
    task automatic t_preset;
        @(posedge clk) pins[3] <= 1'b1;
        @(posedge clk) pins[3] <= 1'b0;
        tick(3);
        chk(io_val[0], 32'h1);
        @(posedge clk) pins[4:3] <= 2'h3;
        @(posedge clk) pins[4:3] <= 2'h0;
        tick(3);
        chk(io_val[0], 32'h0);
    endtask
    task automatic t_secure;
        wr32(8'hC0, 32'h1234_5678);
        wr32(8'hC1, 32'h9ABC_DEF0);
        rd32(8'hA0, rv);
        chk(rv, 32'h800);
        @(posedge clk) sec <= 1'b1;
        @(posedge clk) sec <= 1'b0;
        tick(1);
        chk(secured, 32'h1);
        rd32(8'hA0, rv);
        chk(rv, 32'h0);
        rd32(8'hC0, rv);
        chk(rv, 32'h1234_5678);
        rd32(8'hC1, rv);
        chk(rv, 32'h9ABC_DEF0);
        preload(1'b1);
        chk(io_val[0], 32'h0);
    endtask
    // Main sequence, fuse programmed last
    initial begin
        t_reset();
        t_config();
        t_comb();
        t_oe();
        t_count();
        t_preload();
        t_preset();
        t_secure();
        end_of_test();
    end
    // Watchdog against a hang
    initial begin
        #50000;
        err_total++;
        end_of_test();
    end
endmodule
